// File: core/rxsa_defs.svh
// Purpose: Register indices, field positions, reset values and counts
//          for the receive framer Sa capture and control registers.
// Assumes: Index is the printed offset; byte address is four times it.
// Notes:   Definitions only; include by bare name.
`ifndef RXSA_DEFS_SVH
`define RXSA_DEFS_SVH

// ************************************************************
// Register indices (byte address = index * 4)
// ************************************************************
`define RXSA_IDX_REMOTE_ALARM 10'h068
`define RXSA_IDX_SA4          10'h069
`define RXSA_IDX_SA5          10'h06a
`define RXSA_IDX_SA6          10'h06b
`define RXSA_IDX_SA7          10'h06c
`define RXSA_IDX_SA8          10'h06d
`define RXSA_IDX_LAST_SA      10'h06e
`define RXSA_IDX_SA6_CODE     10'h06f
`define RXSA_IDX_MASTER_MODE  10'h080
`define RXSA_IDX_CONTROL_ONE  10'h081

// ************************************************************
// Master mode fields
// ************************************************************
`define RXSA_MM_ENABLE        7
`define RXSA_MM_INIT_DONE     6
`define RXSA_MM_SOFT_RESET    1
`define RXSA_MM_STANDARD      0
`define RXSA_MM_WRITE_MASK    8'hc3
`define RXSA_MM_RESET         8'h00

// ************************************************************
// Receive control one fields (T1 meaning)
// ************************************************************
`define RXSA_RC1_SYNC_TIME    7
`define RXSA_RC1_ZERO_SUB     6
`define RXSA_RC1_FRAMING      5
`define RXSA_RC1_RESYNC_CRIT  4
`define RXSA_RC1_SYNC_CRIT    3
`define RXSA_RC1_JAPAN_CRC    2
`define RXSA_RC1_AUTO_DIS     1
`define RXSA_RC1_RESYNC       0
`define RXSA_RC1_RESET        8'h00

// ************************************************************
// Counts
// ************************************************************
`define RXSA_QUALIFY_SHORT    5'h0a
`define RXSA_QUALIFY_LONG     5'h18
`define RXSA_SA6_LAST_SAMPLE  2'h3

`endif

// File: core/rxsa_pkg.sv
// Purpose: Shared types for the receive framer register block.
// Assumes: Constants live in rxsa_defs.svh.
// Notes:   Types only.
package rxsa_pkg;

  // Framer operating state
  typedef enum logic [1:0] {
    st_wait_init = 2'b00,
    st_low_power = 2'b01,
    st_run       = 2'b10,
    st_held      = 2'b11
  } rxsa_run_state_type;

endpackage

// File: core/rxsa_odd_capture.sv
// Purpose: One byte of bits received in the odd frames of a multiframe.
// Assumes: slot is (frame number - 1) / 2 of an odd frame.
// Notes:   Frame 15 lands in bit 7, frame 1 in bit 0.
`timescale 1ns/1ns
`default_nettype none

module rxsa_odd_capture #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Capture
  input  wire logic                     capture,
  input  wire logic [$clog2(WIDTH)-1:0] slot,
  input  wire logic                     bit_in,
  // Stored byte
  output logic      [WIDTH-1:0]         value_reg
);

  logic [WIDTH-1:0] value_next;

  // Replace only the addressed slot
  always_comb begin
    value_next       = value_reg;
    value_next[slot] = bit_in;
  end

  // Older slots keep last multiframe's value until overwritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= '0;
    end else if (capture) begin
      value_reg <= value_next;
    end
  end

endmodule

`default_nettype wire

// File: core/rxsa_framer_regs.sv
// Purpose: APB register group for receive framer Sa capture and control.
// Assumes: Framer datapath inputs are synchronous to pclk.
// Notes:   Zero wait state slave; read data latched in setup cycle.
`timescale 1ns/1ns
`default_nettype none
`include "rxsa_defs.svh"

//Behaviour
//- Remote alarm odd frames into one byte
//- Each Sa4..Sa8 kept per odd frame
//- Last Sa4..Sa8 in bits four to zero
//- Monitored Sa change raises status event
//- Sa6 codeword reported unaligned in bits 3:0
//- Codes 8, A, F as their rotations
//- Codes C, E as their rotations
//- Enable bit gates low power or running
//- Init done starts operation if enabled
//- Soft reset holds receiver, keeps registers
//- Bit zero selects T1 or E1 receive
//- Sync time selects 10 or 24 bits
//- T1 B8ZS decode enable
//- T1 framing ESF or D4 select
//- Resync on OOF or LOS, or OOF
//- D4 search sequential or cross coupled
//- ESF search FPS only or CRC checked
//- Standard or Japanese CRC-6 select
//- Auto resync enable or disable
//- Rising resync bit starts one resync
module rxsa_framer_regs #(
  parameter int ADDR_WIDTH = 12
) (
  // APB slave
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Received frame bits from the framer datapath
  input  wire logic                  odd_frame_strobe,
  input  wire logic [3:0]            frame_number,
  input  wire logic                  remote_alarm_bit,
  input  wire logic [4:0]            national_bits,
  input  wire logic [4:0]            national_bit_monitor_mask,
  // Resync causes
  input  wire logic                  oof_event,
  input  wire logic                  los_event,
  // Receive control toward the framer
  output logic                       framer_active,
  output logic                       framer_low_power,
  output logic                       receiver_soft_reset,
  output logic                       rx_line_standard_select,
  output logic                       sync_qualify_length,
  output logic      [4:0]            sync_qualify_count,
  output logic                       rx_zero_substitution_enable,
  output logic                       rx_framing_format_select,
  output logic                       auto_resync_criteria,
  output logic                       sync_search_criteria,
  output logic                       japanese_crc_select,
  output logic                       auto_resync_disable,
  output logic                       resync_start,
  output logic                       auto_resync_request,
  output logic                       national_change_event
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0]                    master_mode_reg;
  logic [7:0]                    control_one_reg;
  logic [31:0]                   prdata_reg;
  logic [4:0]                    last_sa_reg;
  logic [3:0]                    sa6_shift_reg;
  logic [3:0]                    sa6_code_reg;
  logic [1:0]                    sa6_count_reg;
  logic                          resync_pulse_reg;
  logic                          change_pulse_reg;
  logic                          auto_req_reg;
  rxsa_pkg::rxsa_run_state_type  state_reg;
  rxsa_pkg::rxsa_run_state_type  state_next;
  logic [7:0]                    odd_bytes [0:5];
  logic [5:0]                    capture_bits;

  // ************************************************************
  // APB decode
  // ************************************************************
  // Low address bits ignored; every register is one aligned word
  wire [9:0]  reg_index  = paddr[11:2];
  wire        setup_ph   = psel & ~penable;
  wire        access_ph  = psel & penable;
  wire        lane_zero  = pstrb[0];
  wire        hit_ra     = (reg_index == `RXSA_IDX_REMOTE_ALARM);
  wire        hit_sa4    = (reg_index == `RXSA_IDX_SA4);
  wire        hit_sa5    = (reg_index == `RXSA_IDX_SA5);
  wire        hit_sa6    = (reg_index == `RXSA_IDX_SA6);
  wire        hit_sa7    = (reg_index == `RXSA_IDX_SA7);
  wire        hit_sa8    = (reg_index == `RXSA_IDX_SA8);
  wire        hit_last   = (reg_index == `RXSA_IDX_LAST_SA);
  wire        hit_code   = (reg_index == `RXSA_IDX_SA6_CODE);
  wire        hit_mm     = (reg_index == `RXSA_IDX_MASTER_MODE);
  wire        hit_rc1    = (reg_index == `RXSA_IDX_CONTROL_ONE);
  wire        hit_any    = hit_ra | hit_sa4 | hit_sa5 | hit_sa6 | hit_sa7
                         | hit_sa8 | hit_last | hit_code | hit_mm | hit_rc1;
  wire        wr_mm      = access_ph & pwrite & hit_mm & lane_zero;
  wire        wr_rc1     = access_ph & pwrite & hit_rc1 & lane_zero;

  // Handshake answers are combinational: no wait states
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata  = prdata_reg;

  // Read mux; status bytes sit in the low lane, the rest reads zero
  wire [7:0] read_byte =
      hit_ra   ? odd_bytes[5] :
      hit_sa4  ? odd_bytes[4] :
      hit_sa5  ? odd_bytes[3] :
      hit_sa6  ? odd_bytes[2] :
      hit_sa7  ? odd_bytes[1] :
      hit_sa8  ? odd_bytes[0] :
      hit_last ? {3'h0, last_sa_reg} :
      hit_code ? {4'h0, sa6_code_reg} :
      hit_mm   ? master_mode_reg :
      hit_rc1  ? control_one_reg :
                 8'h00;

  // Latch read data in setup so it is steady through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= {24'h00_0000, read_byte};
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // Reserved master mode bits never store, so they read zero
  wire [7:0] mm_next = pwdata[7:0] & `RXSA_MM_WRITE_MASK;

  // Soft reset leaves these alone; only presetn clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_mode_reg <= `RXSA_MM_RESET;
      control_one_reg <= `RXSA_RC1_RESET;
    end else begin
      if (wr_mm) begin
        master_mode_reg <= mm_next;
      end
      if (wr_rc1) begin
        control_one_reg <= pwdata[7:0];
      end
    end
  end

  wire mm_enable = master_mode_reg[`RXSA_MM_ENABLE];
  wire mm_init   = master_mode_reg[`RXSA_MM_INIT_DONE];
  wire mm_srst   = master_mode_reg[`RXSA_MM_SOFT_RESET];
  wire mm_e1     = master_mode_reg[`RXSA_MM_STANDARD];
  wire t1_mode   = ~mm_e1;

  // ************************************************************
  // Operating state
  // ************************************************************
  // Enable is only looked at once init done is up
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rxsa_pkg::st_wait_init: begin
        if (mm_init) begin
          state_next = mm_enable ? rxsa_pkg::st_run
                                 : rxsa_pkg::st_low_power;
        end
      end
      rxsa_pkg::st_low_power: begin
        if (!mm_init) begin
          state_next = rxsa_pkg::st_wait_init;
        end else if (mm_enable) begin
          state_next = rxsa_pkg::st_run;
        end
      end
      rxsa_pkg::st_run: begin
        if (!mm_init) begin
          state_next = rxsa_pkg::st_wait_init;
        end else if (!mm_enable) begin
          state_next = rxsa_pkg::st_low_power;
        end else if (mm_srst) begin
          state_next = rxsa_pkg::st_held;
        end
      end
      rxsa_pkg::st_held: begin
        // Level sensitive: stays held while the bit is high
        if (!mm_srst) begin
          state_next = (mm_enable && mm_init) ? rxsa_pkg::st_run
                                              : rxsa_pkg::st_wait_init;
        end
      end
      default: begin
        state_next = rxsa_pkg::st_wait_init;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= rxsa_pkg::st_wait_init;
    end else begin
      state_reg <= state_next;
    end
  end

  wire running = (state_reg == rxsa_pkg::st_run);

  // Mode outputs follow the stored bits; framer_active follows the run state
  assign framer_active           = running;
  assign framer_low_power        = ~mm_enable;
  assign receiver_soft_reset     = mm_srst;
  assign rx_line_standard_select = mm_e1;

  // ************************************************************
  // T1 receive controls
  // ************************************************************
  // T1 meanings except auto resync disable and resync are masked off in E1 so they cannot leak across
  assign sync_qualify_length =
      t1_mode & control_one_reg[`RXSA_RC1_SYNC_TIME];
  assign sync_qualify_count  = sync_qualify_length ?
      `RXSA_QUALIFY_LONG : `RXSA_QUALIFY_SHORT;
  assign rx_zero_substitution_enable =
      t1_mode & control_one_reg[`RXSA_RC1_ZERO_SUB];
  assign rx_framing_format_select =
      t1_mode & control_one_reg[`RXSA_RC1_FRAMING];
  assign auto_resync_criteria =
      t1_mode & control_one_reg[`RXSA_RC1_RESYNC_CRIT];
  // Same bit: D4 cross coupling, or ESF CRC-6 confirmation
  assign sync_search_criteria =
      t1_mode & control_one_reg[`RXSA_RC1_SYNC_CRIT];
  assign japanese_crc_select =
      t1_mode & control_one_reg[`RXSA_RC1_JAPAN_CRC];
  assign auto_resync_disable =
      control_one_reg[`RXSA_RC1_AUTO_DIS];

  // Automatic resync cause, OOF always, LOS unless excluded
  wire auto_cause = oof_event | (los_event & ~auto_resync_criteria);
  wire auto_next  = running & ~auto_resync_disable & auto_cause;

  // Resync fires only on a written low-to-high of bit zero
  wire resync_rise = wr_rc1 & pwdata[`RXSA_RC1_RESYNC]
                   & ~control_one_reg[`RXSA_RC1_RESYNC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_pulse_reg <= 1'b0;
      auto_req_reg     <= 1'b0;
    end else begin
      resync_pulse_reg <= resync_rise;
      auto_req_reg     <= auto_next;
    end
  end

  assign resync_start        = resync_pulse_reg;
  assign auto_resync_request = auto_req_reg;

  // ************************************************************
  // Odd frame capture
  // ************************************************************
  // Only odd E1 frames while running; held receiver keeps old bytes
  wire       capture_go = odd_frame_strobe & frame_number[0]
                        & running & mm_e1;
  wire [2:0] odd_slot   = frame_number[3:1];

  // Index 5 remote alarm, 4..0 Sa4..Sa8
  assign capture_bits = {remote_alarm_bit, national_bits};

  generate
    for (genvar g = 0; g < 6; g++) begin : g_odd
      rxsa_odd_capture #(
        .WIDTH(8)
      ) u_capture (
        .pclk     (pclk),
        .presetn  (presetn),
        .capture  (capture_go),
        .slot     (odd_slot),
        .bit_in   (capture_bits[g]),
        .value_reg(odd_bytes[g])
      );
    end
  endgenerate

  // ************************************************************
  // Last Sa bits, change event, Sa6 codeword
  // ************************************************************
  wire [4:0] sa_changed   = (national_bits ^ last_sa_reg)
                          & national_bit_monitor_mask;
  wire       change_hit   = capture_go & (|sa_changed);
  wire       sa6_bit      = national_bits[2];
  wire       sa6_full     = (sa6_count_reg == `RXSA_SA6_LAST_SAMPLE);

  // Sa6 is sampled with no submultiframe alignment, so the
  // report is any rotation of the codeword; decoding is software's
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_sa_reg      <= 5'h00;
      change_pulse_reg <= 1'b0;
      sa6_shift_reg    <= 4'h0;
      sa6_count_reg    <= 2'h0;
      sa6_code_reg     <= 4'h0;
    end else begin
      change_pulse_reg <= change_hit;
      if (capture_go) begin
        last_sa_reg   <= national_bits;
        sa6_shift_reg <= {sa6_shift_reg[2:0], sa6_bit};
        sa6_count_reg <= sa6_count_reg + 2'h1;
        if (sa6_full) begin
          sa6_code_reg <= {sa6_shift_reg[2:0], sa6_bit};
        end
      end
    end
  end

  assign national_change_event = change_pulse_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mm_reserved_zero_a: assert property (
    (master_mode_reg & ~`RXSA_MM_WRITE_MASK) == 8'h00)
    else $error("reserved master mode bit set");
  apb_unmapped_a: assert property (
    access_ph && !hit_any |-> pslverr)
    else $error("unmapped access without error");
  resync_edge_a: assert property (
    resync_start |-> control_one_reg[0] && !$past(control_one_reg[0]))
    else $error("resync pulse without rising bit");
  qualify_len_a: assert property (
    sync_qualify_length |-> sync_qualify_count == 5'h18)
    else $error("long qualify count wrong");
  last_sa_a: assert property (
    capture_go |=> last_sa_reg == $past(national_bits))
    else $error("last Sa bits not captured");
  alarm_slot_a: assert property (
    capture_go && &odd_slot |=> odd_bytes[5][7] == $past(remote_alarm_bit))
    else $error("frame 15 alarm not in bit 7");
  change_evt_a: assert property (
    change_hit |=> national_change_event
                   ##1 !national_change_event || $past(change_hit))
    else $error("change event not raised");
  run_gate_a: assert property (
    framer_active |-> $past(mm_enable) && $past(mm_init))
    else $error("running without enable and init");
  soft_hold_a: assert property (
    &{running, mm_srst, mm_enable, mm_init} |=> state_reg == rxsa_pkg::st_held)
    else $error("soft reset did not hold receiver");
  zero_sub_a: assert property (
    rx_zero_substitution_enable |-> !mm_e1 && control_one_reg[6])
    else $error("B8ZS enabled outside T1");

endmodule

`default_nettype wire

// File: tb/rxsa_line_model.sv
// Purpose: Far-end line terminal that feeds framed E1 bits to the block.
// Assumes: One frame every two clocks, frames 0 to 15 for each start.
// Notes:   Outside the odd frame strobes the bits read inverted.
`timescale 1ns/1ns
`default_nettype none
module rxsa_line_model (
  // Clock, reset and control
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [7:0]  ra_byte,
  input  wire logic [39:0] sa_bytes,
  // Frame bits toward the block
  output logic             odd_frame_strobe,
  output logic [3:0]       frame_number,
  output logic             remote_alarm_bit,
  output logic [4:0]       national_bits,
  output logic             busy
);
  logic       phase;
  logic [2:0] slot;
  logic       keep;
  // Frame sequencer, one multiframe per start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      phase <= 1'b0;
      frame_number <= 4'h0;
    end else if (busy) begin
      phase <= ~phase;
      if (phase) frame_number <= frame_number + 4'h1;
      if (phase && frame_number == 4'hf) busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end
  end
  // Inverse bits elsewhere, so stale data never looks right
  assign slot = frame_number[3:1];
  assign odd_frame_strobe = busy & ~phase;
  assign keep = odd_frame_strobe & frame_number[0];
  assign remote_alarm_bit = ra_byte[slot] ^ ~keep;
  assign national_bits = {sa_bytes[32+slot], sa_bytes[24+slot],
    sa_bytes[16+slot], sa_bytes[8+slot], sa_bytes[slot]} ^ {5{~keep}};
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the framer register group.
// Assumes: Zero wait APB slave; one port only.
// Notes:   Line model sends whole multiframes of eight captures.
`timescale 1ns/1ns
`default_nettype none
`include "rxsa_defs.svh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'h1, st = 4'h1;
  logic pready, pslverr, er, oof_event = 0, los_event = 0, start = 0;
  logic [4:0] national_bit_monitor_mask = 0, national_bits, cur, prv;
  logic [4:0] sync_qualify_count;
  logic [7:0] ra_byte = 0, v;
  logic [39:0] sa_bytes = 0;
  logic [3:0] frame_number, p;
  logic odd_frame_strobe, remote_alarm_bit, busy, framer_active;
  logic framer_low_power, receiver_soft_reset, rx_line_standard_select;
  logic sync_qualify_length, rx_zero_substitution_enable;
  logic rx_framing_format_select, auto_resync_criteria;
  logic sync_search_criteria, japanese_crc_select, auto_resync_disable;
  logic resync_start, auto_resync_request, national_change_event;
  logic [6:0] ctl;
  int n_fail = 0, n_tests = 0, cyc = 0, n_ev = 0, e;
  logic [3:0] pats [5] = '{4'h8, 4'h5, 4'h9, 4'hb, 4'hf};

  rxsa_framer_regs dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .odd_frame_strobe, .frame_number, .remote_alarm_bit, .national_bits,
    .national_bit_monitor_mask, .oof_event, .los_event, .framer_active,
    .framer_low_power, .receiver_soft_reset, .rx_line_standard_select,
    .sync_qualify_length, .sync_qualify_count, .rx_zero_substitution_enable,
    .rx_framing_format_select, .auto_resync_criteria, .sync_search_criteria,
    .japanese_crc_select, .auto_resync_disable, .resync_start,
    .auto_resync_request, .national_change_event);
  rxsa_line_model line (.pclk, .presetn, .start, .ra_byte, .sa_bytes,
    .odd_frame_strobe, .frame_number, .remote_alarm_bit, .national_bits,
    .busy);

  assign ctl = {sync_qualify_length, rx_zero_substitution_enable,
    rx_framing_format_select, auto_resync_criteria, sync_search_criteria,
    japanese_crc_select, auto_resync_disable};

  // Clock, hang guard and change event counter
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (national_change_event === 1'b1) n_ev++;
    if (cyc == 6000) begin
      n_fail++;
      close_out();
    end
  end

  // ************
  // Tasks
  // ************
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({er, rd}, {1'b0, 24'h0, exp});
  endtask
  task automatic nx();
    @(posedge pclk);
    #1;
  endtask
  // Send one multiframe and wait for the model to finish
  task automatic mf(input logic [7:0] ra, input logic [39:0] sa);
    @(posedge pclk);
    ra_byte <= ra;
    sa_bytes <= sa;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    do @(posedge pclk); while (busy === 1'b1);
  endtask

  // ************
  // Main sequence
  // ************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk({framer_low_power, sync_qualify_count}, 6'h2a);
    for (int i = 0; i < 10; i++)
      rchk(i < 8 ? 10'h068 + 10'(i) : 10'h078 + 10'(i), 8'h00);
    apb(1'b0, 10'h070, 8'h00);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, `RXSA_IDX_SA4, 8'hff);
    chk(er, 0);
    rchk(`RXSA_IDX_SA4, 8'h00);
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'h3c);
    st = 4'h0;
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'hff);
    st = 4'h1;
    rchk(`RXSA_IDX_MASTER_MODE, 8'h00);
    $display("access test done");
    // T1 run and control fields
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'h80);
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'hc0);
    nx();
    chk({framer_active, framer_low_power}, 2'b10);
    for (int b = 1; b < 8; b++) begin
      v = 8'h01 << b;
      apb(1'b1, `RXSA_IDX_CONTROL_ONE, v);
      nx();
      chk(ctl, v[7:1]);
      chk(sync_qualify_count, b == 7 ? 5'h18 : 5'h0a);
      rchk(`RXSA_IDX_CONTROL_ONE, v);
    end
    apb(1'b1, `RXSA_IDX_CONTROL_ONE, 8'h01);
    #1;
    chk(resync_start, 1);
    nx();
    chk(resync_start, 0);
    apb(1'b1, `RXSA_IDX_CONTROL_ONE, 8'h01);
    #1;
    chk(resync_start, 0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `RXSA_IDX_CONTROL_ONE, {3'h0, c[1], 2'h0, c[0], 1'b0});
      for (int o = 0; o < 4; o++) begin
        @(posedge pclk);
        oof_event <= o[1];
        los_event <= o[0];
        nx();
        chk(auto_resync_request, !c[0] & (o[1] | o[0] & !c[1]));
      end
    end
    $display("control test done");
    // E1 mode gates the T1 fields except auto resync disable and resync, and enables capture
    apb(1'b1, `RXSA_IDX_CONTROL_ONE, 8'hfe);
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'hc1);
    nx();
    chk({rx_line_standard_select, ctl}, 8'h81);
    @(posedge pclk);
    national_bit_monitor_mask <= 5'h15;
    n_ev = 0;
    mf(8'h96, 40'h01_80_5a_c3_3c);
    e = 0;
    prv = 5'h0;
    for (int s = 0; s < 8; s++) begin
      cur = {sa_bytes[32+s], sa_bytes[24+s], sa_bytes[16+s],
             sa_bytes[8+s], sa_bytes[s]};
      if (((cur ^ prv) & 5'h15) != 0) e++;
      prv = cur;
    end
    chk(n_ev, e);
    rchk(`RXSA_IDX_REMOTE_ALARM, 8'h96);
    for (int k = 0; k < 5; k++)
      rchk(`RXSA_IDX_SA4 + 10'(k), sa_bytes[8*(4-k) +: 8]);
    rchk(`RXSA_IDX_LAST_SA, 8'h0a);
    rchk(`RXSA_IDX_SA6_CODE, 8'h0a);
    for (int k = 0; k < 5; k++) begin
      p = pats[k];
      mf(8'h00, {16'h0, p[0], p[1], p[2], p[3], 20'h0});
      rchk(`RXSA_IDX_SA6_CODE, {4'h0, p});
    end
    $display("capture test done");
    // Soft reset stops capture but keeps registers
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'hc3);
    nx();
    chk({framer_active, receiver_soft_reset}, 2'b01);
    mf(8'hff, {40{1'b1}});
    rchk(`RXSA_IDX_REMOTE_ALARM, 8'h00);
    rchk(`RXSA_IDX_MASTER_MODE, 8'hc3);
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'hc1);
    nx();
    chk(framer_active, 1);
    apb(1'b1, `RXSA_IDX_MASTER_MODE, 8'h41);
    nx();
    chk({framer_active, framer_low_power}, 2'b01);
    $display("mode test done");
    close_out();
  end
endmodule
`default_nettype wire
